//--- verilog/emsc_pkg.sv
package emsc_pkg;

   // Oscillator periods per machine cycle
   localparam int unsigned EMSC_MC_CLKS_LONG = 12;
   localparam int unsigned EMSC_MC_CLKS_SHORT = 6;
   // Machine cycles the reset pin must stay high
   localparam int unsigned EMSC_RST_HOLD_MCYC = 2;
   // Half-cycle slot where the fetch strobe goes active
   localparam logic [3:0] EMSC_FETCH_SLOT = 4'h2;
   // First phase of the data read/write strobe
   localparam logic [3:0] EMSC_DATA_STROBE_FIRST = 4'h2;
   // Cycles after bus reset until the strap synchroniser is valid
   localparam logic [1:0] EMSC_STRAP_SETTLE = 2'h3;
   // Read-back shaping of special register bits
   localparam logic [7:0] EMSC_FIXED_ZERO_MASK = 8'h04;
   localparam logic [7:0] EMSC_FIXED_ONE_MASK = 8'h00;
   localparam logic [7:0] EMSC_SPEC_READ_RST = 8'h00;

   typedef enum logic [1:0] {
      EMSC_XS_IDLE = 2'b00,
      EMSC_XS_PEND = 2'b01,
      EMSC_XS_ACT = 2'b10
   } emsc_xstate_type;

endpackage

//--- verilog/emsc_sync.sv
`timescale 1ns/1ns
module emsc_sync #(
   parameter int unsigned WIDTH = 1
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Asynchronous in, synchronised out
   input wire logic [WIDTH-1:0] i_async,
   output logic [WIDTH-1:0] o_sync
);
   logic [WIDTH-1:0] stage1;

   if (WIDTH < 1) begin : g_chk
      $error("emsc_sync: WIDTH must be at least 1");
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         stage1 <= '0;
         o_sync <= '0;
      end else begin
         stage1 <= i_async;
         o_sync <= stage1;
      end
   end
endmodule // emsc_sync

//--- verilog/emsc_rst_qual.sv
`timescale 1ns/1ns
module emsc_rst_qual
   import emsc_pkg::*;
#(
   parameter int unsigned MC_LONG = EMSC_MC_CLKS_LONG,
   parameter int unsigned MC_SHORT = EMSC_MC_CLKS_SHORT,
   parameter int unsigned HOLD_MCYC = EMSC_RST_HOLD_MCYC
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Synchronised reset pin level and active mode
   input wire logic i_reset_level,
   input wire logic i_six_clock_mode,
   // Qualified device reset
   output logic o_device_reset
);
   logic [5:0] cnt;
   logic [5:0] thr;
   logic [5:0] hi_len;

   if (HOLD_MCYC < 1 || HOLD_MCYC * MC_LONG > 63 || MC_SHORT > MC_LONG) begin : g_chk
      $error("emsc_rst_qual: hold length does not fit the counter");
   end

   always_comb begin
      thr = i_six_clock_mode ? 6'(HOLD_MCYC * MC_SHORT) : 6'(HOLD_MCYC * MC_LONG);
   end

   // Reset only after the full hold time of high samples
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         cnt <= 6'h00;
         o_device_reset <= 1'b0;
      end else if (!i_reset_level) begin
         cnt <= 6'h00;
         o_device_reset <= 1'b0;
      end else if (cnt < thr - 6'h01) begin
         cnt <= cnt + 6'h01;
      end else begin
         o_device_reset <= 1'b1;
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         hi_len <= 6'h00;
      end else if (!i_reset_level) begin
         hi_len <= 6'h00;
      end else if (hi_len != 6'h3F) begin
         hi_len <= hi_len + 6'h01;
      end
   end

   AST_RST_HOLD: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      $rose(o_device_reset) |-> hi_len >= thr)
      else $error("device reset rose before the hold time");

   AST_RST_RELEASE: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
      !i_reset_level |=> !o_device_reset)
      else $error("device reset stayed after pin went low");
endmodule // emsc_rst_qual

//--- verilog/emsc_top.sv
// Behaviour
// - Internal fetch keeps the program fetch strobe high.
// - External fetch pulses the program fetch strobe twice per machine cycle.
// - A data access cycle drops both program fetch strobe pulses.
// - Reset pin high for two machine cycles resets; outside must hold it.
// - External fetch select low selects external program memory.
// - External fetch select high selects internal program memory.
// - Address latch strobe marks the low address byte for the latch.
// - Long mode emits address latch strobe at one sixth of oscillator.
// - Exactly one address latch strobe pulse dropped per data access.
// - Latch strobe off set to one silences the address latch strobe.
// - Short mode emits address latch strobe at one third of oscillator.
// - Write strobe goes active while writing external data memory.
// - Read strobe goes active while reading external data memory.
// - Reserved bits written zero; read-back value is unspecified.
// - Fixed-zero bits written zero and always read zero.
// - Fixed-one bits written one and always read one.
`timescale 1ns/1ns
module emsc_top
   import emsc_pkg::*;
#(
   parameter int unsigned MC_LONG = EMSC_MC_CLKS_LONG,
   parameter int unsigned MC_SHORT = EMSC_MC_CLKS_SHORT,
   parameter logic [7:0] FIXED_ZERO_MASK = EMSC_FIXED_ZERO_MASK,
   parameter logic [7:0] FIXED_ONE_MASK = EMSC_FIXED_ONE_MASK
) (
   // Clock and reset
   input wire logic i_sys_clk,
   input wire logic i_rst_n,
   // Device pins in
   input wire logic i_reset_pin,
   input wire logic i_external_fetch_select,
   // Core controls
   input wire logic i_six_clock_mode,
   input wire logic i_latch_strobe_off,
   // External data access request
   input wire logic i_xdata_req,
   input wire logic i_xdata_write,
   output logic o_xdata_busy,
   output logic o_xdata_done,
   // Special register read-back
   input wire logic [7:0] i_spec_raw,
   output logic [7:0] o_spec_read_data,
   // Device pins out
   output logic o_address_latch_strobe,
   output logic o_program_fetch_strobe_n,
   output logic o_data_read_strobe_n,
   output logic o_data_write_strobe_n,
   // Status
   output logic o_device_reset,
   output logic o_fetch_external,
   output logic o_machine_cycle_start,
   output logic o_six_clock_active
);
   logic reset_s, fetch_sel_s, dev_rst, strap_done, six_q, lso_q;
   logic [1:0] strap_wait;
   logic [3:0] phase, hp;
   logic wrap, second_half, xwrite, act, in_strobe;
   emsc_xstate_type xstate, next_xstate;
   logic next_ale, next_program_fetch_strobe_n, next_rd_n, next_wr_n;

   if (MC_LONG > 15 || MC_SHORT < 6 || MC_LONG % 2 != 0 || MC_SHORT % 2 != 0 || MC_SHORT > MC_LONG)
   begin : g_chk_mc
      $error("emsc_top: machine cycle lengths not supported");
   end
   if ((FIXED_ZERO_MASK & FIXED_ONE_MASK) != 8'h00) begin : g_chk_mask
      $error("emsc_top: a bit cannot be fixed at both zero and one");
   end

   function automatic logic [3:0] half_len(input logic six);
      return six ? 4'(MC_SHORT / 2) : 4'(MC_LONG / 2);
   endfunction

   function automatic logic [3:0] mc_last(input logic six);
      return six ? 4'(MC_SHORT - 1) : 4'(MC_LONG - 1);
   endfunction

   function automatic logic [3:0] half_phase(input logic [3:0] ph, input logic six);
      logic [3:0] hl;
      hl = half_len(six);
      return (ph >= hl) ? ph - hl : ph;
   endfunction

   emsc_sync #(
      .WIDTH(2)
   ) u_pin_sync (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_async({i_reset_pin, i_external_fetch_select}),
      .o_sync({reset_s, fetch_sel_s})
   );

   emsc_rst_qual #(
      .MC_LONG(MC_LONG),
      .MC_SHORT(MC_SHORT),
      .HOLD_MCYC(EMSC_RST_HOLD_MCYC)
   ) u_rst_qual (
      .i_sys_clk(i_sys_clk),
      .i_rst_n(i_rst_n),
      .i_reset_level(reset_s),
      .i_six_clock_mode(six_q),
      .o_device_reset(dev_rst)
   );

   assign strap_done = (strap_wait == EMSC_STRAP_SETTLE);

   // Wait until the synchroniser carries the real strap level
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         strap_wait <= 2'h0;
      end else if (!strap_done) begin
         strap_wait <= strap_wait + 2'h1;
      end
   end

   // Strap follows the pin during reset, frozen on release
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_fetch_external <= 1'b0;
      end else if (dev_rst || !strap_done) begin
         o_fetch_external <= !fetch_sel_s;
      end
   end

   // Mode and latch-off change only on a machine cycle boundary or during device reset
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         six_q <= 1'b0;
         lso_q <= 1'b0;
      end else if (dev_rst || wrap) begin
         six_q <= i_six_clock_mode;
         lso_q <= i_latch_strobe_off;
      end
   end

   assign wrap = (phase == mc_last(six_q));
   assign hp = half_phase(phase, six_q);
   assign second_half = (phase >= half_len(six_q));

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || dev_rst) begin
         phase <= 4'h0;
      end else if (wrap) begin
         phase <= 4'h0;
      end else begin
         phase <= phase + 4'h1;
      end
   end

   always_comb begin
      next_xstate = xstate;
      case (xstate)
         EMSC_XS_IDLE: begin
            if (i_xdata_req) begin
               next_xstate = EMSC_XS_PEND;
            end
         end
         EMSC_XS_PEND: begin
            if (wrap) begin
               next_xstate = EMSC_XS_ACT;
            end
         end
         EMSC_XS_ACT: begin
            if (wrap) begin
               next_xstate = EMSC_XS_IDLE;
            end
         end
         default: begin
            next_xstate = EMSC_XS_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || dev_rst) begin
         xstate <= EMSC_XS_IDLE;
         xwrite <= 1'b0;
         o_xdata_busy <= 1'b0;
         o_xdata_done <= 1'b0;
      end else begin
         xstate <= next_xstate;
         if (xstate == EMSC_XS_IDLE && i_xdata_req) begin
            xwrite <= i_xdata_write;
         end
         o_xdata_busy <= (next_xstate != EMSC_XS_IDLE);
         o_xdata_done <= (xstate == EMSC_XS_ACT) && wrap;
      end
   end

   assign act = (xstate == EMSC_XS_ACT);
   assign in_strobe = act && phase >= EMSC_DATA_STROBE_FIRST && phase < mc_last(six_q);

   always_comb begin
      next_ale = !lso_q && hp == 4'h0 && !(act && second_half);
      next_program_fetch_strobe_n = !(o_fetch_external && hp >= EMSC_FETCH_SLOT && !act);
      next_rd_n = !(in_strobe && !xwrite);
      next_wr_n = !(in_strobe && xwrite);
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || dev_rst) begin
         o_address_latch_strobe <= 1'b0;
         o_program_fetch_strobe_n <= 1'b1;
         o_data_read_strobe_n <= 1'b1;
         o_data_write_strobe_n <= 1'b1;
         o_machine_cycle_start <= 1'b0;
      end else begin
         o_address_latch_strobe <= next_ale;
         o_program_fetch_strobe_n <= next_program_fetch_strobe_n;
         o_data_read_strobe_n <= next_rd_n;
         o_data_write_strobe_n <= next_wr_n;
         o_machine_cycle_start <= (phase == 4'h0);
      end
   end

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_device_reset <= 1'b0;
         o_six_clock_active <= 1'b0;
      end else begin
         o_device_reset <= dev_rst;
         o_six_clock_active <= six_q;
      end
   end

   // Reserved bits pass raw, fixed bits forced
   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n) begin
         o_spec_read_data <= (EMSC_SPEC_READ_RST & ~FIXED_ZERO_MASK) | FIXED_ONE_MASK;
      end else begin
         o_spec_read_data <= (i_spec_raw & ~FIXED_ZERO_MASK) | FIXED_ONE_MASK;
      end
   end

   // Helper state aligned with the registered outputs
   logic act_out, wr_out, lso_out, program_fetch_strobe_d, ale_d, program_fetch_strobe_fall, ale_rise;
   logic win_ok, win_data, win_ext, win_off, win_six;
   logic [2:0] program_fetch_strobe_falls, ale_rises;
   logic [3:0] mc_len, wr_low_len;

   assign program_fetch_strobe_fall = program_fetch_strobe_d && !o_program_fetch_strobe_n;
   assign ale_rise = !ale_d && o_address_latch_strobe;

   always_ff @(posedge i_sys_clk) begin
      if (!i_rst_n || dev_rst) begin
         act_out <= 1'b0;
         wr_out <= 1'b0;
         lso_out <= 1'b0;
         program_fetch_strobe_d <= 1'b1;
         ale_d <= 1'b0;
         program_fetch_strobe_falls <= 3'h0;
         ale_rises <= 3'h0;
         win_ok <= 1'b0;
         win_data <= 1'b0;
         win_ext <= 1'b0;
         win_off <= 1'b0;
         win_six <= 1'b0;
         mc_len <= 4'h0;
         wr_low_len <= 4'h0;
      end else begin
         act_out <= act;
         wr_out <= xwrite;
         lso_out <= lso_q;
         program_fetch_strobe_d <= o_program_fetch_strobe_n;
         ale_d <= o_address_latch_strobe;
         wr_low_len <= (!o_data_write_strobe_n && o_data_read_strobe_n) ? wr_low_len + 4'h1 : 4'h0;
         if (o_machine_cycle_start) begin
            program_fetch_strobe_falls <= {2'h0, program_fetch_strobe_fall};
            ale_rises <= {2'h0, ale_rise};
            win_ok <= strap_done;
            win_data <= act_out;
            win_ext <= o_fetch_external;
            win_off <= lso_out;
            win_six <= o_six_clock_active;
            mc_len <= 4'h1;
         end else begin
            program_fetch_strobe_falls <= program_fetch_strobe_falls + {2'h0, program_fetch_strobe_fall};
            ale_rises <= ale_rises + {2'h0, ale_rise};
            mc_len <= mc_len + 4'h1;
         end
      end
   end

   default clocking cb @(posedge i_sys_clk);
   endclocking
   default disable iff (!i_rst_n || dev_rst);

   sequence s_write_long_end;
      o_data_write_strobe_n && wr_low_len == 4'(MC_LONG - 3);
   endsequence

   sequence s_cycle_short;
      !o_machine_cycle_start [*5] ##1 o_machine_cycle_start;
   endsequence

   sequence s_closed_window;
      o_machine_cycle_start && win_ok;
   endsequence

   AST_INT_FETCH_HIGH: assert property (win_ok && !o_fetch_external |-> o_program_fetch_strobe_n)
      else $error("fetch strobe active during internal fetch");
   AST_FETCH_TWICE: assert property (s_closed_window and win_ext && !win_data |-> program_fetch_strobe_falls == 3'h2)
      else $error("fetch strobe not pulsed twice in a machine cycle");
   AST_FETCH_SKIP: assert property (s_closed_window and win_data |-> program_fetch_strobe_falls == 3'h0)
      else $error("fetch strobe pulsed during a data access cycle");
   AST_STRAP: assert property ($fell(o_device_reset) |-> o_fetch_external == !$past(fetch_sel_s, 2))
      else $error("fetch source does not follow the strap");
   AST_LATCH_ADDR: assert property (o_machine_cycle_start && act_out && !lso_out |-> o_address_latch_strobe)
      else $error("no address latch strobe at data access start");
   AST_ALE_RATE: assert property (s_closed_window and !win_off && !win_data |-> ale_rises == 3'h2)
      else $error("address latch strobe not two per machine cycle");
   AST_ALE_DROP: assert property (s_closed_window and !win_off && win_data |-> ale_rises == 3'h1)
      else $error("data access did not drop exactly one latch strobe");
   AST_ALE_OFF: assert property (lso_out |-> !o_address_latch_strobe)
      else $error("address latch strobe active while switched off");
   AST_CYCLE_SHORT: assert property (o_machine_cycle_start && o_six_clock_active |-> ##1 s_cycle_short)
      else $error("short machine cycle is not six clocks");
   AST_CYCLE_LONG: assert property (o_machine_cycle_start && win_ok && !win_six |-> mc_len == 4'(MC_LONG))
      else $error("long machine cycle is not twelve clocks");
   AST_WRITE_STROBE: assert property (o_machine_cycle_start && act_out && wr_out && !o_six_clock_active |->
      ##2 (!o_data_write_strobe_n && o_data_read_strobe_n) ##9 s_write_long_end)
      else $error("write strobe window wrong");
   AST_READ_STROBE: assert property (o_machine_cycle_start && act_out && !wr_out && o_six_clock_active |->
      ##2 (!o_data_read_strobe_n && o_data_write_strobe_n) [*3] ##1 o_data_read_strobe_n)
      else $error("read strobe window wrong");
   AST_FIXED_BITS: assert property ((o_spec_read_data & FIXED_ZERO_MASK) == 8'h00 &&
      (o_spec_read_data & FIXED_ONE_MASK) == FIXED_ONE_MASK)
      else $error("fixed special register bits read wrong");
endmodule // emsc_top

//--- dv/emsc_xmem_model.sv
`timescale 1ns/1ns
module emsc_xmem_model (
   // Strobes from the device
   input wire logic i_ale,
   input wire logic i_fetch_n,
   input wire logic i_rd_n,
   input wire logic i_wr_n,
   // Completed transfers seen by the memory
   output int o_latch_count,
   output int o_fetch_count,
   output int o_xfer_count
);
   logic [7:0] low_addr;

   initial begin
      o_latch_count = 0;
      o_fetch_count = 0;
      o_xfer_count = 0;
      low_addr = 8'h00;
   end

   // Latch closes on the falling strobe and keeps the low address byte
   always @(negedge i_ale) begin
      low_addr = low_addr + 8'h01;
      o_latch_count++;
   end

   // A program word is taken as the fetch strobe ends
   always @(posedge i_fetch_n) begin
      o_fetch_count++;
   end

   // A data transfer completes as either data strobe ends
   always @(posedge i_rd_n or posedge i_wr_n) begin
      o_xfer_count++;
   end
endmodule // emsc_xmem_model

//--- dv/tb_top.sv
`timescale 1ns/1ns
module tb_top
   import emsc_pkg::*;
;
   localparam logic [7:0] ZM = 8'h04;
   localparam logic [7:0] OM = 8'h80;
   localparam int LM = EMSC_MC_CLKS_LONG;
   localparam int SM = EMSC_MC_CLKS_SHORT;

   logic i_sys_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_reset_pin = 1'b0;
   logic i_external_fetch_select = 1'b0;
   logic i_six_clock_mode = 1'b0;
   logic i_latch_strobe_off = 1'b0;
   logic i_xdata_req = 1'b0;
   logic i_xdata_write = 1'b0;
   logic [7:0] i_spec_raw = 8'h00;
   logic o_xdata_busy, o_xdata_done, o_address_latch_strobe, o_program_fetch_strobe_n;
   logic o_data_read_strobe_n, o_data_write_strobe_n, o_device_reset, o_fetch_external;
   logic o_machine_cycle_start, o_six_clock_active;
   logic [7:0] o_spec_read_data;
   int latch_count, fetch_count, xfer_count;
   int fail_count = 0;
   int n_checks = 0;
   int m_ale, m_fetch, m_xfer, m_ale_bad, m_rdlow, m_wrlow, m_done, m_starts;

   always #2 i_sys_clk = ~i_sys_clk;

   emsc_top #(.FIXED_ZERO_MASK(ZM), .FIXED_ONE_MASK(OM)) uut (
      .i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_reset_pin(i_reset_pin),
      .i_external_fetch_select(i_external_fetch_select), .i_six_clock_mode(i_six_clock_mode),
      .i_latch_strobe_off(i_latch_strobe_off), .i_xdata_req(i_xdata_req), .i_xdata_write(i_xdata_write),
      .o_xdata_busy(o_xdata_busy), .o_xdata_done(o_xdata_done), .i_spec_raw(i_spec_raw),
      .o_spec_read_data(o_spec_read_data), .o_address_latch_strobe(o_address_latch_strobe),
      .o_program_fetch_strobe_n(o_program_fetch_strobe_n), .o_data_read_strobe_n(o_data_read_strobe_n),
      .o_data_write_strobe_n(o_data_write_strobe_n), .o_device_reset(o_device_reset),
      .o_fetch_external(o_fetch_external), .o_machine_cycle_start(o_machine_cycle_start),
      .o_six_clock_active(o_six_clock_active)
   );

   emsc_xmem_model mem (
      .i_ale(o_address_latch_strobe), .i_fetch_n(o_program_fetch_strobe_n),
      .i_rd_n(o_data_read_strobe_n), .i_wr_n(o_data_write_strobe_n),
      .o_latch_count(latch_count), .o_fetch_count(fetch_count), .o_xfer_count(xfer_count)
   );

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         fail_count++;
         $display("ERROR t=%0t got=%0h exp=%0h", $time, got, exp);
      end
   endtask

   task automatic give_verdict;
      $display("checks=%0d mismatches=%0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   task automatic wait_start;
      int k;
      for (k = 0; k < 40 && o_machine_cycle_start !== 1'b1; k++) @(negedge i_sys_clk);
      check(o_machine_cycle_start, 1'b1);
   endtask

   // Observes whole machine cycles from one cycle start on
   task automatic measure(input int n_mc, input int mc);
      int lat0, fet0, xf0, k;
      wait_start();
      lat0 = latch_count;
      fet0 = fetch_count;
      xf0 = xfer_count;
      m_ale_bad = 0; m_rdlow = 0; m_wrlow = 0; m_done = 0; m_starts = 0;
      for (k = 0; k < n_mc * mc; k++) begin
         if (o_address_latch_strobe === 1'b1 && (k % (mc / 2)) != 0) m_ale_bad++;
         if (o_machine_cycle_start === 1'b1) m_starts++;
         if (o_data_read_strobe_n === 1'b0) m_rdlow++;
         if (o_data_write_strobe_n === 1'b0) m_wrlow++;
         if (o_xdata_done === 1'b1) m_done++;
         @(negedge i_sys_clk);
      end
      m_ale = latch_count - lat0;
      m_fetch = fetch_count - fet0;
      m_xfer = xfer_count - xf0;
      check(m_starts, n_mc);
      check(o_machine_cycle_start, 1'b1);
      check(m_ale_bad, 0);
   endtask

   task automatic t_plain(input int mc);
      measure(2, mc);
      check(o_fetch_external, 1'b1);
      check(m_ale, 4);
      check(m_fetch, 4);
      check(m_rdlow + m_wrlow, 0);
      $display("test plain mc=%0d done", mc);
   endtask

   // Access, then a request made while busy that must be ignored
   task automatic t_xdata(input logic wr, input int mc);
      wait_start();
      i_xdata_write = wr;
      i_xdata_req = 1'b1;
      @(negedge i_sys_clk);
      i_xdata_req = 1'b0;
      @(negedge i_sys_clk);
      check(o_xdata_busy, 1'b1);
      i_xdata_req = 1'b1;
      i_xdata_write = ~wr;
      @(negedge i_sys_clk);
      i_xdata_req = 1'b0;
      measure(1, mc);
      check(m_ale, 1);
      check(m_fetch, 0);
      check(m_wrlow, wr ? mc - 3 : 0);
      check(m_rdlow, wr ? 0 : mc - 3);
      check(m_xfer, 1);
      check(m_done, 1);
      check(o_xdata_busy, 1'b0);
      measure(1, mc);
      check(m_ale, 2);
      check(m_fetch, 2);
      check(m_rdlow + m_wrlow, 0);
      $display("test xdata wr=%0d mc=%0d done", wr, mc);
   endtask

   task automatic t_short;
      int k;
      i_six_clock_mode = 1'b1;
      for (k = 0; k < 40 && o_six_clock_active !== 1'b1; k++) @(negedge i_sys_clk);
      check(o_six_clock_active, 1'b1);
      t_plain(SM);
      t_xdata(1'b0, SM);
      i_six_clock_mode = 1'b0;
      for (k = 0; k < 40 && o_six_clock_active !== 1'b0; k++) @(negedge i_sys_clk);
      check(o_six_clock_active, 1'b0);
      $display("test short done");
   endtask

   task automatic t_latch_off;
      i_latch_strobe_off = 1'b1;
      measure(1, LM);
      measure(2, LM);
      check(m_ale, 0);
      check(m_fetch, 4);
      i_latch_strobe_off = 1'b0;
      measure(1, LM);
      measure(1, LM);
      check(m_ale, 2);
      $display("test latch off done");
   endtask

   task automatic t_spec;
      logic [7:0] raw [3] = '{8'hFF, 8'h00, 8'h5A};
      int k;
      for (k = 0; k < 3; k++) begin
         i_spec_raw = raw[k];
         @(negedge i_sys_clk);
         @(negedge i_sys_clk);
         check(o_spec_read_data & ZM, 8'h00);
         check(o_spec_read_data & OM, OM);
         check(o_spec_read_data, (raw[k] & ~ZM) | OM);
      end
      $display("test spec done");
   endtask

   // Reset pin held two cycles short of two machine cycles, then long enough
   task automatic t_pin_reset;
      int k, seen;
      i_external_fetch_select = 1'b1;
      seen = 0;
      i_reset_pin = 1'b1;
      for (k = 0; k < 2 * LM - 2; k++) @(negedge i_sys_clk);
      i_reset_pin = 1'b0;
      for (k = 0; k < 8; k++) begin
         if (o_device_reset === 1'b1) seen++;
         @(negedge i_sys_clk);
      end
      check(seen, 0);
      check(o_fetch_external, 1'b1);
      i_reset_pin = 1'b1;
      for (k = 0; k < 2 * LM + 8; k++) begin
         if (o_device_reset === 1'b1) seen++;
         @(negedge i_sys_clk);
      end
      i_reset_pin = 1'b0;
      check(seen > 0, 1'b1);
      for (k = 0; k < 10 && o_device_reset !== 1'b0; k++) @(negedge i_sys_clk);
      check(o_device_reset, 1'b0);
      check(o_fetch_external, 1'b0);
      measure(2, LM);
      check(m_fetch, 0);
      check(o_program_fetch_strobe_n, 1'b1);
      check(m_ale, 4);
      $display("test pin reset done");
   endtask

   initial begin
      repeat (3) @(negedge i_sys_clk);
      i_rst_n = 1'b1;
      repeat (4) @(negedge i_sys_clk);
      t_plain(LM);
      t_xdata(1'b1, LM);
      t_xdata(1'b0, LM);
      t_short();
      t_latch_off();
      t_spec();
      t_pin_reset();
      give_verdict();
   end

   initial begin
      repeat (5000) @(posedge i_sys_clk);
      fail_count++;
      $display("ERROR t=%0t got=%0h exp=%0h", $time, 0, 1);
      give_verdict();
   end
endmodule // tb_top
